// ==== qdac_pkg.sv ====
package qdac_pkg;
   localparam int          WORD_BITS      = 24;
   localparam int          DATA_BITS      = 14;
   localparam int          NUM_CHAN       = 4;
   localparam int          CHAN_BITS      = 2;
   localparam int          CNT_BITS       = 5;
   localparam logic [4:0]  CNT_LAST       = 5'h18;
   // field positions inside the command word
   localparam int          POS_ZERO_HI    = 23;
   localparam int          POS_ZERO_LO    = 22;
   localparam int          POS_LOAD_HI    = 21;
   localparam int          POS_LOAD_LO    = 20;
   localparam int          POS_RSVD       = 19;
   localparam int          POS_SEL_HI     = 18;
   localparam int          POS_SEL_LO     = 17;
   localparam int          POS_PD         = 16;
   localparam int          POS_DATA_HI    = 15;
   localparam int          POS_DATA_LO    = 2;
   // stored value: powerdown flag above the 14-bit field
   localparam int          VAL_BITS       = DATA_BITS + 1;
   localparam logic [14:0] VAL_ZERO       = 15'h0000;
   localparam logic [14:0] VAL_MID        = 15'h2000;
   localparam logic [1:0]  LOAD_STORE     = 2'h0;
   localparam logic [1:0]  LOAD_UPDATE    = 2'h1;
   localparam logic [1:0]  LOAD_SIMUL     = 2'h2;
   localparam logic [1:0]  LOAD_BCAST     = 2'h3;
endpackage : qdac_pkg

// ==== qdac_pin_sync.sv ====
`timescale 1ns/1ps
module qdac_pin_sync
   import qdac_pkg::*;
#(
   parameter int WIDTH = 3
)
(
   input  wire logic             i_sys_clk,
   input  wire logic             i_rstn,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync,
   output logic      [WIDTH-1:0] o_sync_dly
);
   // first stage feeds only the second stage
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] dly_reg;

   always_ff @(posedge i_sys_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         meta_reg <= '1;
         sync_reg <= '1;
         dly_reg  <= '1;
      end
      else
      begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
         dly_reg  <= sync_reg;
      end
   end

   assign o_sync     = sync_reg;
   assign o_sync_dly = dly_reg;
endmodule : qdac_pin_sync

// ==== qdac_serial_port.sv ====
// Operation
// (R1) 24-bit word: control, 14-bit data, two ignored
// (R2) first received bit lands in bit 23
// (R3) sample data on each clock fall while framed
// (R4) lock word after 24th fall, ignore more
// (R5) execute command at 24th fall, not frame end
// (R6) frame select fall starts fresh frame
// (R7) early frame end discards partial word
// (R8) host keeps gap before next frame select fall
// (R9) host limits serial clock rate
// (R10) data field is straight binary
// (R11) reset clears all, outputs zero or mid
// (R12) host releases reset before framing, fixes level
// (R13) host sends zeros in bits 23, 22, 19
// (R14) bits 18:17 choose channel
// (R15) codes 0..3 map to channels a..d
// (R16) bit 16 marks a powerdown command
// (R17) mode 00 writes selected buffer only
// (R18) mode 01 writes selected buffer and dac
// (R19) mode 10 selected from word, others from buffers
// (R20) mode 11 broadcast, address ignored
// (R21) broadcast bit 18 picks buffers or word
// (R22) powerdown mode bits stored as opaque code
`timescale 1ns/1ps
module qdac_serial_port
   import qdac_pkg::*;
#(
   parameter int NCH = NUM_CHAN
)
(
   input  wire logic                          i_sys_clk,
   input  wire logic                          i_rstn,
   input  wire logic                          i_frame_n,
   input  wire logic                          i_sclk,
   input  wire logic                          i_sdata,
   input  wire logic                          i_clear_level_select,
   output logic      [NCH-1:0][VAL_BITS-1:0]  o_dac_value,
   output logic      [NCH-1:0][VAL_BITS-1:0]  o_buf_value,
   output logic                               o_cmd_done
);

   logic [2:0] pin_now;
   logic [2:0] pin_old;

   qdac_pin_sync #(
      .WIDTH (3)
   ) qdac_pin_sync_inst (
      .i_sys_clk  (i_sys_clk),
      .i_rstn     (i_rstn),
      .i_async    ({i_frame_n, i_sclk, i_sdata}),
      .o_sync     (pin_now),
      .o_sync_dly (pin_old)
   );

   logic frame_n;
   logic sclk_fall;
   logic frame_fall;
   logic sdata;

   assign frame_n    = pin_now[2];
   assign sclk_fall  = pin_old[1] & ~pin_now[1];
   assign frame_fall = pin_old[2] & ~pin_now[2];
   // data taken one sample behind the clock fall, so setup before the fall holds
   assign sdata      = pin_old[0];

   typedef struct packed
   {
      logic [WORD_BITS-1:0]          shift;
      logic [CNT_BITS-1:0]           count;
      logic                          locked;
      logic                          framed;
      logic                          done;
      logic                          seeded;
      logic [NCH-1:0][VAL_BITS-1:0]  bufs;
      logic [NCH-1:0][VAL_BITS-1:0]  dacs;
   } qdac_state_type;

   qdac_state_type state_reg;
   qdac_state_type state_next;

   function automatic logic [VAL_BITS-1:0] word_value
   (
      input logic [WORD_BITS-1:0] w
   );
      // powerdown flag rides along so that later loads keep it
      word_value = {w[POS_PD], w[POS_DATA_HI:POS_DATA_LO]}; // see (R22)
   endfunction : word_value

   logic [WORD_BITS-1:0]  word;
   logic [1:0]            load_mode;
   logic [CHAN_BITS-1:0]  chan_sel;
   logic [VAL_BITS-1:0]   rx_value;

   always_comb
   begin
      state_next      = state_reg;
      state_next.done = 1'b0;
      word      = state_reg.shift;
      load_mode = 2'h0;
      chan_sel  = '0;
      rx_value  = '0;
      if (!state_reg.seeded)
      begin
         // reset level caught once after release, not under the reset
         state_next.seeded = 1'b1;
         for (int i = 0; i < NCH; i++)
         begin
            state_next.bufs[i] = i_clear_level_select ? VAL_MID
                                                      : VAL_ZERO; // see (R11)
            state_next.dacs[i] = state_next.bufs[i];
         end
      end
      else if (frame_fall)
      begin
         state_next.count  = '0; // see (R6)
         state_next.locked = 1'b0;
         state_next.framed = 1'b1;
      end
      else if (frame_n)
      begin
         // partial word dropped with no effect on buffers or dacs
         state_next.count  = '0; // see (R7)
         state_next.framed = 1'b0;
      end
      else if (sclk_fall && state_reg.framed && !state_reg.locked) // see (R4)
      begin
         word = {state_reg.shift[WORD_BITS-2:0], sdata}; // see (R2) (R3)
         state_next.shift = word;
         state_next.count = state_reg.count + 5'h01;
         if (state_next.count == CNT_LAST)
         begin
            state_next.locked = 1'b1;
            state_next.done   = 1'b1; // see (R5)
            load_mode = word[POS_LOAD_HI:POS_LOAD_LO]; // see (R1)
            chan_sel  = word[POS_SEL_HI:POS_SEL_LO]; // see (R14) (R15)
            rx_value  = word_value(word); // see (R10) (R16)
            case (load_mode)
               LOAD_STORE:
                  state_next.bufs[chan_sel] = rx_value; // see (R17)
               LOAD_UPDATE:
               begin
                  state_next.bufs[chan_sel] = rx_value; // see (R18)
                  state_next.dacs[chan_sel] = rx_value;
               end
               LOAD_SIMUL:
               begin
                  for (int i = 0; i < NCH; i++)
                     state_next.dacs[i] = state_reg.bufs[i]; // see (R19)
                  state_next.bufs[chan_sel] = rx_value;
                  state_next.dacs[chan_sel] = rx_value;
               end
               LOAD_BCAST:
               begin
                  for (int i = 0; i < NCH; i++) // see (R20)
                  begin
                     if (word[POS_SEL_HI])
                     begin
                        state_next.bufs[i] = rx_value; // see (R21)
                        state_next.dacs[i] = rx_value;
                     end
                     else
                        state_next.dacs[i] = state_reg.bufs[i]; // see (R21)
                  end
               end
               default:
                  state_next.done = 1'b0;
            endcase
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         state_reg <= '0; // see (R11)
      else
         state_reg <= state_next;
   end

   assign o_dac_value = state_reg.dacs;
   assign o_buf_value = state_reg.bufs;
   assign o_cmd_done  = state_reg.done;

   // checks sit next to the decoder they guard
   sequence s_last_fall;
      sclk_fall && !frame_n && !frame_fall && state_reg.framed
         && !state_reg.locked && state_reg.count == 5'h17;
   endsequence

   a_done_on_last: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      s_last_fall |=> o_cmd_done) // see (R5)
      else $error("command not executed on last clock fall");

   a_done_cause: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      o_cmd_done |-> $past(state_reg.count) == 5'h17
         && state_reg.locked) // see (R4)
      else $error("command executed without full word");

   a_lock_holds: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      state_reg.locked && !frame_fall |=> $stable(state_reg.shift)) // see (R4)
      else $error("locked word changed");

   a_frame_restart: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      frame_fall && state_reg.seeded |=> state_reg.count == '0
         && !state_reg.locked) // see (R6)
      else $error("frame start did not clear counter");

   a_abort_keeps: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      frame_n && state_reg.seeded |=> $stable(o_dac_value)
         && $stable(o_buf_value)) // see (R7)
      else $error("idle frame changed outputs");

   a_shift_msb: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      sclk_fall && !frame_n && !frame_fall && state_reg.framed
         && !state_reg.locked && state_reg.seeded
      |=> state_reg.shift[0] == $past(sdata)
         && state_reg.shift[23:1] == $past(state_reg.shift[22:0])) // see (R2)
      else $error("shift order wrong");

   a_store_only: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      o_cmd_done && state_reg.shift[21:20] == LOAD_STORE
      |-> $stable(o_dac_value)) // see (R17)
      else $error("store mode touched dac register");

   a_update_sel: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      o_cmd_done && state_reg.shift[21:20] == LOAD_UPDATE
      |-> o_dac_value[state_reg.shift[18:17]]
         == word_value(state_reg.shift)) // see (R18)
      else $error("update mode missed dac register");

   a_bcast_all: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      o_cmd_done && state_reg.shift[21:20] == LOAD_BCAST
         && state_reg.shift[18]
      |-> o_dac_value[3] == word_value(state_reg.shift)
         && o_dac_value[2] == word_value(state_reg.shift)
         && o_dac_value[1] == word_value(state_reg.shift)
         && o_dac_value[0] == word_value(state_reg.shift)) // see (R21)
      else $error("broadcast did not load all channels");

   a_reset_level: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      !state_reg.seeded |=> o_dac_value[0]
         == (i_clear_level_select ? VAL_MID : VAL_ZERO)) // see (R11)
      else $error("reset level wrong");

   // mode-qualified command completions, plus the seeded idle frame state
   sequence s_simul_done;
      o_cmd_done
         && state_reg.shift[POS_LOAD_HI:POS_LOAD_LO] == LOAD_SIMUL;
   endsequence

   sequence s_bcast_keep_done;
      o_cmd_done
         && state_reg.shift[POS_LOAD_HI:POS_LOAD_LO] == LOAD_BCAST
         && !state_reg.shift[POS_SEL_HI];
   endsequence

   sequence s_store_done;
      o_cmd_done
         && state_reg.shift[POS_LOAD_HI:POS_LOAD_LO] == LOAD_STORE;
   endsequence

   sequence s_idle_seeded;
      frame_n && state_reg.seeded;
   endsequence

   a_simul_match: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      s_simul_done |-> o_dac_value == o_buf_value) // see (R19)
      else $error("simultaneous load left a dac behind its buffer");

   a_simul_sel: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      s_simul_done
      |-> o_dac_value[state_reg.shift[POS_SEL_HI:POS_SEL_LO]]
         == word_value(state_reg.shift)) // see (R19)
      else $error("simultaneous load missed selected channel");

   a_bcast_keep: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      s_bcast_keep_done |-> $stable(o_buf_value)) // see (R21)
      else $error("buffer-only broadcast changed a buffer");

   a_bcast_from_buf: assert property (@(posedge i_sys_clk)
      disable iff (!i_rstn)
      s_bcast_keep_done |-> o_dac_value == o_buf_value) // see (R21)
      else $error("buffer-only broadcast did not load dacs");

   a_store_buf: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      s_store_done
      |-> o_buf_value[state_reg.shift[POS_SEL_HI:POS_SEL_LO]]
         == word_value(state_reg.shift)) // see (R17)
      else $error("store mode missed selected buffer");

   a_pd_carried: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      o_cmd_done
         && state_reg.shift[POS_LOAD_HI:POS_LOAD_LO] == LOAD_UPDATE
      |-> o_dac_value[state_reg.shift[POS_SEL_HI:POS_SEL_LO]][VAL_BITS-1]
         == state_reg.shift[POS_PD]) // see (R16) (R22)
      else $error("powerdown flag not carried");

   a_done_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      o_cmd_done |=> !o_cmd_done) // see (R5)
      else $error("completion pulse longer than one cycle");

   a_locked_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      state_reg.locked |=> !o_cmd_done) // see (R4)
      else $error("command executed twice in one frame");

   a_idle_clears: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      s_idle_seeded |=> state_reg.count == '0
         && !state_reg.framed) // see (R7)
      else $error("idle frame select left port armed");

   a_idle_shift: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      s_idle_seeded |=> $stable(state_reg.shift)) // see (R7)
      else $error("shift register moved outside a frame");

   a_count_bound: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      state_reg.count <= CNT_LAST) // see (R4)
      else $error("bit counter ran past word length");

   a_start_keeps: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      frame_fall && state_reg.seeded |=> $stable(o_dac_value)
         && $stable(o_buf_value)) // see (R6)
      else $error("frame start changed outputs");
endmodule : qdac_serial_port

// ==== qdac_host_model.sv ====
`timescale 1ns/1ps
module qdac_host_model
(
   input  wire logic i_sys_clk,
   output logic      o_frame_n,
   output logic      o_sclk,
   output logic      o_sdata
);
   initial
   begin
      o_frame_n = 1'b1;
      o_sclk    = 1'b1;
      o_sdata   = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask : tick

   // serial clock 80 ns, idle high so no stray fall outside frames
   task automatic send(input logic [23:0] w, input int nbits,
                       input bit keep);
      if (!o_frame_n)
      begin
         o_frame_n = 1'b1;
         tick(8);
      end
      o_frame_n = 1'b0;
      tick(4);
      for (int i = 0; i < nbits; i++)
      begin
         o_sdata = (i < 24) ? w[23-i] : ~o_sdata;
         tick(4);
         o_sclk = 1'b0;
         tick(4);
         o_sclk = 1'b1;
      end
      tick(4);
      if (!keep)
         o_frame_n = 1'b1;
      // released line shows the inverse, not a stale bit
      o_sdata = ~o_sdata;
      tick(8);
   endtask : send
endmodule : qdac_host_model

// ==== qdac_serial_port_test.sv ====
`timescale 1ns/1ps
module qdac_serial_port_test;
   import qdac_pkg::*;
   logic                              sys_clk;
   logic                              rstn;
   logic                              level_sel;
   logic                              frame_n;
   logic                              sclk;
   logic                              sdata;
   logic [NUM_CHAN-1:0][VAL_BITS-1:0] dac_value;
   logic [NUM_CHAN-1:0][VAL_BITS-1:0] buf_value;
   logic                              cmd_done;
   logic [VAL_BITS-1:0]               exp_dac [NUM_CHAN];
   logic [VAL_BITS-1:0]               exp_buf [NUM_CHAN];
   int                                mismatches;
   int                                checked;
   int                                done_cnt;

   qdac_serial_port qdac_serial_port_inst (
      .i_sys_clk            (sys_clk),
      .i_rstn               (rstn),
      .i_frame_n            (frame_n),
      .i_sclk               (sclk),
      .i_sdata              (sdata),
      .i_clear_level_select (level_sel),
      .o_dac_value          (dac_value),
      .o_buf_value          (buf_value),
      .o_cmd_done           (cmd_done)
   );

   qdac_host_model qdac_host_model_inst (
      .i_sys_clk (sys_clk),
      .o_frame_n (frame_n),
      .o_sclk    (sclk),
      .o_sdata   (sdata)
   );

   always #5 sys_clk = ~sys_clk;

   always @(posedge sys_clk)
      if (cmd_done === 1'b1)
         done_cnt++;

   task automatic close_out();
      $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out

   task automatic fail(input string msg);
      mismatches++;
      $display("Error at %0t: %s", $time, msg);
   endtask : fail

   task automatic check_all(input string name);
      for (int c = 0; c < NUM_CHAN; c++)
      begin
         checked++;
         if (dac_value[c] !== exp_dac[c] || buf_value[c] !== exp_buf[c])
            fail($sformatf("ch %0d dac %h buf %h", c, dac_value[c],
                           buf_value[c]));
      end
      $display("Test %s done", name);
   endtask : check_all

   task automatic do_reset(input logic lvl);
      @(posedge sys_clk);
      #1;
      rstn      = 1'b0;
      level_sel = lvl;
      repeat (6) @(posedge sys_clk);
      #1;
      rstn = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      for (int c = 0; c < NUM_CHAN; c++)
      begin
         exp_dac[c] = lvl ? VAL_MID : VAL_ZERO;
         exp_buf[c] = lvl ? VAL_MID : VAL_ZERO;
      end
   endtask : do_reset

   // bits 1:0 sent as ones since the port must ignore them
   task automatic cmd(input logic [1:0] mode, input logic [1:0] sel,
                      input logic [14:0] v, input int nbits,
                      input bit keep);
      logic [23:0] w;
      int          start;
      w     = {2'b00, mode, 1'b0, sel, v, 2'b11};
      start = done_cnt;
      qdac_host_model_inst.send(w, nbits, keep);
      for (int i = 0; i < 20 && done_cnt == start; i++)
         @(posedge sys_clk);
      #1;
      if (nbits >= 24)
         case (mode)
            LOAD_STORE:  exp_buf[sel] = v;
            LOAD_UPDATE:
            begin
               exp_buf[sel] = v;
               exp_dac[sel] = v;
            end
            LOAD_SIMUL:
            begin
               exp_buf[sel] = v;
               exp_dac      = exp_buf;
            end
            default:
               for (int c = 0; c < NUM_CHAN; c++)
               begin
                  if (sel[1])
                     exp_buf[c] = v;
                  exp_dac[c] = exp_buf[c];
               end
         endcase
      checked++;
      if (done_cnt - start != int'(nbits >= 24))
      begin
         fail("command completion count wrong");
         if (nbits >= 24)
            close_out();
      end
      check_all($sformatf("mode %0d sel %0d bits %0d", mode, sel, nbits));
   endtask : cmd

   initial
   begin
      sys_clk    = 1'b0;
      rstn       = 1'b0;
      level_sel  = 1'b1;
      mismatches = 0;
      checked    = 0;
      done_cnt   = 0;
      do_reset(1'b1);
      check_all("reset mid");
      for (int c = 0; c < NUM_CHAN; c++)
         cmd(LOAD_STORE, c[1:0], 15'(14'h1a5 + c), 24, 0);
      cmd(LOAD_UPDATE, 2'h1, 15'h3fff, 24, 0);
      cmd(LOAD_UPDATE, 2'h0, 15'h0000, 24, 0);
      cmd(LOAD_UPDATE, 2'h3, 15'h1234, 23, 0);
      cmd(LOAD_STORE, 2'h3, 15'h0555, 20, 0);
      cmd(LOAD_UPDATE, 2'h2, 15'h2aaa, 28, 1);
      cmd(LOAD_STORE, 2'h3, 15'h0555, 24, 0);
      cmd(LOAD_SIMUL, 2'h2, 15'h4321, 24, 0);
      cmd(LOAD_STORE, 2'h0, 15'h7001, 24, 0);
      cmd(LOAD_BCAST, 2'h1, 15'h1111, 24, 0);
      cmd(LOAD_BCAST, 2'h3, 15'h4002, 24, 0);
      do_reset(1'b0);
      check_all("reset zero");
      close_out();
   end
endmodule : qdac_serial_port_test
